// File: hw/tsense_pkg.sv
// Shared constants for the serial temperature sensor link and its host.
// Assumes a 20 MHz system clock on both ends and an idle-high select.
package tsense_pkg;

	// Word layout: 14-bit two's complement value above two constant ones.
	localparam int WORD_W = 16;
	localparam int DATA_W = 14;
	localparam int CMD_W = 8;
	localparam logic [1:0] PAD_BITS = 2'h3;
	// One value step in micro-degrees Celsius (0.03125 degC).
	localparam int TEMP_STEP_UDEG = 31250;

	// Frame layout in serial clocks.
	localparam int READ_BITS = 16;
	localparam int WRITE_BITS = 16;
	localparam int FRAME_BITS = READ_BITS + WRITE_BITS;
	// The 8th write bit lands on this rising-edge count (counted from 0).
	localparam int CMD_LAST_EDGE = FRAME_BITS - CMD_W - 1;

	// The only two command codes; others may enter a factory test mode.
	localparam logic [CMD_W-1:0] CODE_SHUTDOWN = 8'hff;
	localparam logic [CMD_W-1:0] CODE_CONTINUOUS = 8'h00;
	localparam logic [CMD_W-1:0] CODE_UPPER_FILL = 8'h00;

	// Identification: 5-bit maker code, 9-bit device code, both arbitrary.
	localparam logic [4:0] MAKER_CODE = 5'h13;
	localparam logic [8:0] DEVICE_CODE = 9'h0a5;
	localparam logic [DATA_W-1:0] TEMP_RESET = 14'h0000;

	// Timing, in nanoseconds as specified, and derived clock counts.
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCLK_PERIOD_MIN_NS = 160;
	localparam int CS_SETUP_MIN_NS = 100;
	localparam int CS_HOLD_MIN_NS = 50;
	localparam int CS_GAP_MIN_NS = 160;
	localparam int SYNC_STAGES = 3;

	localparam int HALF_MIN_CYC =
		(SCLK_PERIOD_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// A half period must cover the host synchroniser, whose output follows
	// the line one cycle after its last stage, plus the sampling edge.
	// Otherwise each bit is taken one falling edge late.
	localparam int HALF_CYC = (HALF_MIN_CYC > SYNC_STAGES + 1) ?
		HALF_MIN_CYC : SYNC_STAGES + 2;
	localparam int SETUP_MIN_CYC =
		(CS_SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Extra setup lets the device freeze its outgoing word first.
	localparam int SETUP_CYC = SETUP_MIN_CYC + SYNC_STAGES + 1;
	localparam int HOLD_CYC =
		(CS_HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC =
		(CS_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	function automatic logic [WORD_W-1:0] pack_word(
		input logic [DATA_W-1:0] value
	);
		pack_word = {value, PAD_BITS};
	endfunction

endpackage

// File: hw/tsense_link_if.sv
// Three-wire link between the sensor end and the host end.
// The shared data line is resolved here; it idles high when nobody drives.
`timescale 1ns/10ps
`default_nettype none
interface tsense_link_if;
	logic sel_n;
	logic serial_bus_clock;
	logic dev_o;
	logic dev_oe;
	logic host_o;
	logic host_oe;
	logic data_line;

	assign data_line = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);

	modport device (
		input sel_n,
		input serial_bus_clock,
		input data_line,
		output dev_o,
		output dev_oe
	);

	modport host (
		output sel_n,
		output serial_bus_clock,
		output host_o,
		output host_oe,
		input data_line
	);
endinterface
`default_nettype wire

// File: hw/sync3.sv
// Three-stage input synchroniser with an agreement filter.
// Assumes a level input from another clock domain or a pin.
`timescale 1ns/10ps
`default_nettype none
module sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change is taken only once the second and third stages agree.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= RESET_VAL;
		end else if (s2_q == s3_q) begin
			q <= s3_q;
		end
	end
endmodule
`default_nettype wire

// File: hw/tsense_device.sv
// Sensor end: temperature and identification readout plus mode command.
// Assumes the host keeps the serial clock still while select is high and
// gives the select fall some setup so the outgoing word is frozen first.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// (RULE1) Temperature is 14-bit two's complement, 0.03125 degC.
// (RULE2) Word bits 15..2 carry temperature, sign first.
// (RULE3) Two lowest word bits always sent as one.
// (RULE4) Most significant byte and bit go first.
// (RULE5) Host may stop a read early.
// (RULE6) Low byte all ones selects shutdown.
// (RULE7) Low byte all zeros selects continuous conversion.
// (RULE8) Upper command byte is ignored.
// (RULE9) Other codes may enter test mode.
// (RULE10) Link keeps working during shutdown.
// (RULE11) Shutdown reads return the identification word.
// (RULE12) Identification: maker code, device code, two ones.
// (RULE13) Identification shown whenever in shutdown.
// (RULE14) Two read-only registers, one write-only register.
// (RULE15) Shift out on falling, sample on rising.
// (RULE16) Sixteen read clocks, then up to sixteen write.
// (RULE17) Act on last eight write bits only.
// (RULE18) Reset gives defaults and continuous conversion.
// (RULE19) Frame start loads temperature or identification.
module tsense_device
	import tsense_pkg::*;
#(
	parameter logic [4:0] MAKER = MAKER_CODE,
	parameter logic [8:0] DEVICE = DEVICE_CODE
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [DATA_W-1:0] temp_in,
	input wire logic temp_valid,
	output logic shutdown,
	output logic test_mode,
	tsense_link_if.device link
);

	// System-clock domain state.
	logic sel_s;
	logic sel_prev_q;
	logic sel_rise;
	logic cmd_ready_s;
	logic cmd_ready_prev_q;
	logic cmd_pend_q;
	logic [DATA_W-1:0] temp_q;
	logic [WORD_W-1:0] word_q;
	logic [DATA_W-1:0] ident;

	// Link-clock domain state.
	logic frame_rst_n;
	logic [4:0] tx_idx_q;
	logic [5:0] rx_cnt_q;
	logic [CMD_W-1:0] rx_sr_q;
	logic cmd_ready_q;
	logic [3:0] tx_bit;

	// Select and the command-ready level enter the system domain here.
	sync3 #(
		.RESET_VAL(1'b1)
	) u_sel_sync (
		.clk(clk),
		.rstn(rstn),
		.d(link.sel_n),
		.q(sel_s)
	);

	sync3 #(
		.RESET_VAL(1'b0)
	) u_cmd_sync (
		.clk(clk),
		.rstn(rstn),
		.d(cmd_ready_q),
		.q(cmd_ready_s)
	);

	assign sel_rise = sel_s & ~sel_prev_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sel_prev_q <= 1'b1;
		end else begin
			sel_prev_q <= sel_s;
		end
	end

	// Each write frame with eight or more write bits raises the ready level once. The link side only
	// lowers it at the next frame's first clock, so a frame cut before any
	// clock must not replay the previous code: a code is taken once.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_ready_prev_q <= 1'b0;
		end else begin
			cmd_ready_prev_q <= cmd_ready_s;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_pend_q <= 1'b0;
		end else if (cmd_ready_s && !cmd_ready_prev_q) begin
			cmd_pend_q <= 1'b1; // RULE17
		end else if (sel_rise) begin
			cmd_pend_q <= 1'b0;
		end
	end

	// The converter is idle in shutdown, so the last result is kept.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			temp_q <= TEMP_RESET; // RULE18
		end else if (temp_valid && !shutdown) begin
			temp_q <= temp_in; // RULE1
		end
	end

	assign ident = {MAKER, DEVICE}; // RULE12

	// The command byte is decoded once the frame has ended; the received
	// byte stays still then because the serial clock is stopped.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shutdown <= 1'b0; // RULE18
			test_mode <= 1'b0;
		end else if (sel_rise && cmd_pend_q) begin // RULE17
			unique case (rx_sr_q) // RULE8
				CODE_SHUTDOWN: begin
					shutdown <= 1'b1; // RULE6
				end
				CODE_CONTINUOUS: begin
					shutdown <= 1'b0; // RULE7
				end
				default: begin
					test_mode <= 1'b1; // RULE9
				end
			endcase
		end
	end

	// The outgoing word follows the mode only between frames, so a frame
	// always sees one consistent word. There is no path that returns the
	// command byte: it is write-only.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			word_q <= pack_word(TEMP_RESET);
		end else if (sel_s) begin
			if (shutdown) begin
				word_q <= pack_word(ident); // RULE11 RULE13 RULE19
			end else begin
				word_q <= pack_word(temp_q); // RULE2 RULE3 RULE19
			end
		end
	end

	// RULE14
	// Link-side counters are cleared while select is high; a host that
	// leaves early therefore loses nothing but the rest of the word.
	assign frame_rst_n = rstn & ~link.sel_n; // RULE5

	// Falling edges advance the bit being driven.
	always_ff @(negedge link.serial_bus_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_idx_q <= 5'h00;
		end else if (tx_idx_q != 5'(READ_BITS)) begin
			tx_idx_q <= tx_idx_q + 5'h01; // RULE15
		end
	end

	// Rising edges are counted across the whole frame.
	always_ff @(posedge link.serial_bus_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rx_cnt_q <= 6'h00;
		end else if (rx_cnt_q != 6'(FRAME_BITS)) begin
			rx_cnt_q <= rx_cnt_q + 6'h01; // RULE16
		end
	end

	// Write-phase bits are sampled on the rising edge into eight bits, so
	// only the last eight survive. Fewer than eight leaves the mode alone.
	always_ff @(posedge link.serial_bus_clock or negedge rstn) begin
		if (!rstn) begin
			rx_sr_q <= CODE_CONTINUOUS;
			cmd_ready_q <= 1'b0;
		end else begin
			if (rx_cnt_q >= 6'(READ_BITS) &&
				rx_cnt_q < 6'(FRAME_BITS)) begin
				rx_sr_q <= {rx_sr_q[CMD_W-2:0], link.data_line}; // RULE17
			end
			if (rx_cnt_q >= 6'(CMD_LAST_EDGE) &&
				rx_cnt_q < 6'(FRAME_BITS)) begin
				cmd_ready_q <= 1'b1; // RULE17
			end else if (rx_cnt_q == 6'h00) begin
				cmd_ready_q <= 1'b0;
			end
		end
	end

	// Most significant bit first; the word is read straight from the frozen
	// register, so bit 15 is on the line as soon as select falls.
	assign tx_bit = 4'hf - tx_idx_q[3:0]; // RULE4
	assign link.dev_o = word_q[tx_bit];

	// The line is driven in shutdown too; only test mode goes silent.
	assign link.dev_oe = ~link.sel_n & ~tx_idx_q[4] & ~test_mode; // RULE10

endmodule
`default_nettype wire

// File: hw/tsense_host.sv
// Host end: the link master. Makes select and the serial clock from clk.
// Assumes the sensor end is joined through tsense_link_if.
`timescale 1ns/10ps
`default_nettype none
module tsense_host
	import tsense_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic req,
	input wire logic req_write,
	input wire logic req_shutdown,
	output logic busy,
	output logic done,
	output logic [WORD_W-1:0] rd_word,
	tsense_link_if.host link
);
	typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} hstate_t;

	hstate_t state_q;
	logic [7:0] tmr_q;
	logic [5:0] bit_q;
	logic [5:0] total_q;
	logic [WORD_W-1:0] wr_sr_q;
	logic [WORD_W-1:0] rd_sr_q;
	logic sel_n_q;
	logic sclk_q;
	logic host_o_q;
	logic host_oe_q;
	logic din_s;
	logic [5:0] bit_next;

	sync3 #(
		.RESET_VAL(1'b1)
	) u_din_sync (
		.clk(clk),
		.rstn(rstn),
		.d(link.data_line),
		.q(din_s)
	);

	assign bit_next = bit_q + 6'h01;
	assign link.sel_n = sel_n_q;
	assign link.serial_bus_clock = sclk_q;
	assign link.host_o = host_o_q;
	assign link.host_oe = host_oe_q;

	// Only the two defined codes can be formed: the request is one bit.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= H_IDLE;
			tmr_q <= 8'h00;
			bit_q <= 6'h00;
			total_q <= 6'h00;
			wr_sr_q <= 16'h0000;
			rd_sr_q <= 16'h0000;
			sel_n_q <= 1'b1;
			sclk_q <= 1'b0;
			host_o_q <= 1'b0;
			host_oe_q <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			rd_word <= 16'h0000;
		end else begin
			done <= 1'b0;
			unique case (state_q)
				H_IDLE: begin
					if (req) begin
						sel_n_q <= 1'b0;
						busy <= 1'b1;
						bit_q <= 6'h00;
						total_q <= req_write ? 6'(FRAME_BITS) : 6'(READ_BITS);
						wr_sr_q <= {CODE_UPPER_FILL,
							req_shutdown ? CODE_SHUTDOWN : CODE_CONTINUOUS};
						tmr_q <= 8'(SETUP_CYC - 1);
						state_q <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (tmr_q == 8'h00) begin
						tmr_q <= 8'(HALF_CYC - 1);
						state_q <= H_LOW;
					end else begin
						tmr_q <= tmr_q - 8'h01;
					end
				end
				H_LOW: begin
					if (tmr_q == 8'h00) begin
						sclk_q <= 1'b1;
						if (bit_q < 6'(READ_BITS)) begin
							rd_sr_q <= {rd_sr_q[WORD_W-2:0], din_s};
						end
						tmr_q <= 8'(HALF_CYC - 1);
						state_q <= H_HIGH;
					end else begin
						tmr_q <= tmr_q - 8'h01;
					end
				end
				H_HIGH: begin
					if (tmr_q == 8'h00) begin
						sclk_q <= 1'b0;
						bit_q <= bit_next;
						if (bit_next == total_q) begin
							host_oe_q <= 1'b0;
							tmr_q <= 8'(HOLD_CYC - 1);
							state_q <= H_HOLD;
						end else begin
							// The sensor lets go of the line on this same edge.
							if (bit_next >= 6'(READ_BITS)) begin
								host_oe_q <= 1'b1;
								host_o_q <= wr_sr_q[WORD_W-1];
								wr_sr_q <= {wr_sr_q[WORD_W-2:0], 1'b0};
							end
							tmr_q <= 8'(HALF_CYC - 1);
							state_q <= H_LOW;
						end
					end else begin
						tmr_q <= tmr_q - 8'h01;
					end
				end
				H_HOLD: begin
					if (tmr_q == 8'h00) begin
						sel_n_q <= 1'b1;
						rd_word <= rd_sr_q;
						done <= 1'b1;
						tmr_q <= 8'(GAP_CYC - 1);
						state_q <= H_GAP;
					end else begin
						tmr_q <= tmr_q - 8'h01;
					end
				end
				H_GAP: begin
					if (tmr_q == 8'h00) begin
						busy <= 1'b0;
						state_q <= H_IDLE;
					end else begin
						tmr_q <= tmr_q - 8'h01;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: bench/tsense_checker.sv
// Concurrent checks on the three-wire link between sensor and host.
// Assumes the clk domain samples every link signal; no bind is used.
`timescale 1ns/10ps
`default_nettype none
module tsense_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sel_n,
	input wire logic serial_bus_clock,
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic host_o,
	input wire logic host_oe,
	input wire logic data_line
);
	logic sclk_q;
	logic [5:0] rise_cnt_q;
	logic rise;

	assign rise = serial_bus_clock && !sclk_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			sclk_q <= 1'b0;
		else
			sclk_q <= serial_bus_clock;
	end

	// Rising edges seen in the open frame; select high clears it.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rise_cnt_q <= 6'h00;
		else if (sel_n)
			rise_cnt_q <= 6'h00;
		else if (rise)
			rise_cnt_q <= rise_cnt_q + 6'h01;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_sclk_idle_still: assert property (sel_n |-> !serial_bus_clock)
		else $error("link clock moved outside a frame");
	a_dev_quiet_idle: assert property (sel_n |-> !dev_oe)
		else $error("sensor drives data while deselected");
	a_no_contention: assert property (!(dev_oe && host_oe))
		else $error("both ends drive the data line");
	a_select_setup: assert property ($fell(sel_n) |-> !serial_bus_clock [*5])
		else $error("clock rose too soon after select");
	a_clock_high_len: assert property ($rose(serial_bus_clock) |=>
		serial_bus_clock [*3])
		else $error("link clock high phase too short");
	a_dev_hold_high: assert property (serial_bus_clock && sclk_q && dev_oe
		|-> $stable(dev_o))
		else $error("sensor data changed while clock high");
	a_host_hold_high: assert property (serial_bus_clock && sclk_q && host_oe
		|-> $stable(host_o))
		else $error("host data changed while clock high");
	a_pad_bits_one: assert property (rise && dev_oe &&
		(rise_cnt_q == 6'h0e || rise_cnt_q == 6'h0f) |-> data_line)
		else $error("low word bit not one");
	a_write_release: assert property (rise && rise_cnt_q >= 6'h10
		|-> !dev_oe && rise_cnt_q < 6'h20)
		else $error("write phase broken");

	c_read_frame: cover property (rise && rise_cnt_q == 6'h0f && dev_oe);
	c_write_frame: cover property (rise && rise_cnt_q == 6'h1f);
	c_host_drives: cover property (host_oe && !host_o);
endmodule
`default_nettype wire

// File: bench/tb.sv
// Testbench joining the sensor end and the host end over the link.
// Assumes the host makes select and the link clock from clk.
`timescale 1ns/10ps
`default_nettype none
module tb
	import tsense_pkg::*;
;
	logic clk;
	logic rstn;
	logic [DATA_W-1:0] temp_in;
	logic temp_valid;
	logic req;
	logic req_write;
	logic req_shutdown;
	logic shutdown;
	logic test_mode;
	logic busy;
	logic done;
	logic [WORD_W-1:0] rd_word;
	logic [15:0] id_word;
	logic [13:0] tv [4];
	int n_mismatch;
	int n_tests;

	tsense_link_if i_tsense_link_if ();
	tsense_device i_tsense_device (.clk(clk), .rstn(rstn),
		.temp_in(temp_in), .temp_valid(temp_valid), .shutdown(shutdown),
		.test_mode(test_mode), .link(i_tsense_link_if));
	tsense_host i_tsense_host (.clk(clk), .rstn(rstn), .req(req),
		.req_write(req_write), .req_shutdown(req_shutdown), .busy(busy),
		.done(done), .rd_word(rd_word), .link(i_tsense_link_if));
	tsense_checker i_tsense_checker (.clk(clk), .rstn(rstn),
		.sel_n(i_tsense_link_if.sel_n),
		.serial_bus_clock(i_tsense_link_if.serial_bus_clock),
		.dev_o(i_tsense_link_if.dev_o), .dev_oe(i_tsense_link_if.dev_oe),
		.host_o(i_tsense_link_if.host_o),
		.host_oe(i_tsense_link_if.host_oe),
		.data_line(i_tsense_link_if.data_line));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task test_done();
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One whole frame; the fixed tail covers the gap and the mode update.
	task xfer(input logic w, input logic s);
		int i;
		@(posedge clk);
		req <= 1'b1;
		req_write <= w;
		req_shutdown <= s;
		@(posedge clk);
		req <= 1'b0;
		for (i = 0; i < 400 && done !== 1'b1; i++)
			@(negedge clk);
		if (i >= 400) begin
			n_mismatch++;
			test_done();
		end
		repeat (10) @(negedge clk);
		chk("busy", 16'h0000, {15'h0000, busy});
	endtask

	task load(input logic [13:0] t);
		@(posedge clk);
		temp_in <= t;
		temp_valid <= 1'b1;
		@(posedge clk);
		temp_valid <= 1'b0;
	endtask

	initial begin
		tv = '{14'h12c0, 14'h3fff, 14'h3b00, 14'h0001};
		id_word = {MAKER_CODE, DEVICE_CODE, 2'h3};
		n_mismatch = 0;
		n_tests = 0;
		rstn = 1'b0;
		temp_in = 14'h0000;
		temp_valid = 1'b0;
		req = 1'b0;
		req_write = 1'b0;
		req_shutdown = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("mode", 16'h0000, {14'h0000, test_mode, shutdown});
		xfer(1'b0, 1'b0);
		chk("word", {TEMP_RESET, 2'h3}, rd_word);
		foreach (tv[k]) begin
			load(tv[k]);
			xfer(1'b0, 1'b0);
			chk("temp", {tv[k], 2'h3}, rd_word);
		end
		xfer(1'b1, 1'b1);
		chk("wr_rd", {tv[3], 2'h3}, rd_word);
		chk("sd", 16'h0001, {15'h0000, shutdown});
		load(14'h2000);
		xfer(1'b0, 1'b0);
		chk("id", id_word, rd_word);
		xfer(1'b1, 1'b1);
		chk("id2", id_word, rd_word);
		xfer(1'b1, 1'b0);
		chk("id3", id_word, rd_word);
		chk("cont", 16'h0000, {15'h0000, shutdown});
		xfer(1'b0, 1'b0);
		chk("back", {tv[3], 2'h3}, rd_word);
		chk("tm", 16'h0000, {15'h0000, test_mode});
		test_done();
	end
endmodule
`default_nettype wire
